// *** rtl/phy_mgmt_consts.svh ***
// Offsets, field positions, reset values and bank numbers of the PHY
// management register bank.
// Assumes a word-addressed bus: byte address is four times the index.
`ifndef PHY_MGMT_CONSTS_SVH
`define PHY_MGMT_CONSTS_SVH

// ==========================================================================
// Register indices (byte address = index * 4)
`define PM_IDX_DIAG       6'h00
`define PM_IDX_ALIAS      6'h00
`define PM_IDX_SPECIAL    6'h02
`define PM_IDX_ID_LOW     6'h04
`define PM_IDX_ID_HIGH    6'h06
`define PM_IDX_ADV        6'h08
`define PM_IDX_LP         6'h0A
`define PM_IDX_BANK_SEL   6'h0E
`define PM_IDX_IRQ_STAT   6'h10
`define PM_IDX_IRQ_MASK   6'h11

// ==========================================================================
// Bank numbers
`define PM_BANK_PHY       8'h2D
`define PM_BANK_RSVD_A    8'h2E
`define PM_BANK_DIAG      8'h2F
`define PM_BANK_RSVD_B    8'h30
`define PM_BANK_PORT      8'h31

// ==========================================================================
// Field positions
`define PM_ADV_PAUSE      10
`define PM_ADV_RSV9       9
`define PM_ADV_F100       8
`define PM_ADV_H100       7
`define PM_ADV_F10        6
`define PM_ADV_H10        5
`define PM_DIAG_EN        15
`define PM_SPC_FORCE      3
`define PM_SPC_PWRSAVE    2
`define PM_SPC_RLB        1
`define PM_SPC_RSV0       0
`define PM_ALIAS_EN       12
`define PM_ALIAS_FORCE    11
`define PM_ALIAS_PWRSAVE  10
`define PM_ALIAS_RLB      9
`define PM_IRQ_DIAG       0
`define PM_IRQ_LP         1

// ==========================================================================
// Reset values and fixed read values
`define PM_RST_ADV        5'h1F
`define PM_RST_PWRSAVE    1'h1
`define PM_RST_BANK       8'h00
`define PM_SELECTOR       5'h01
`define PM_RESP_OKAY      2'h0
`define PM_RESP_SLVERR    2'h2

`endif

// *** rtl/phy_mgmt_pkg.sv ***
// Types shared by the PHY management register bank.
// Assumes the constants header is compiled alongside.
package phy_mgmt_pkg;

   // =======================================================================
   // AXI4-Lite request and response bundles
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } axil_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_t;

   // =======================================================================
   // PHY side bundles
   typedef struct packed {
      logic pause;
      logic full100;
      logic half100;
      logic full10;
      logic half10;
   } ability_t;

   typedef enum logic [1:0] {
      DIAG_NORMAL = 2'h0,
      DIAG_OPEN   = 2'h1,
      DIAG_SHORT  = 2'h2,
      DIAG_FAIL   = 2'h3
   } diag_code_t;

   typedef struct packed {
      logic       near_short_flag;
      diag_code_t result;
      logic [8:0] fault_count;
   } diag_res_t;

   typedef struct packed {
      logic force_link;
      logic pwrsave_off;
      logic remote_loopback;
   } phy_ctl_t;

endpackage : phy_mgmt_pkg

// *** rtl/phy_mgmt_register_bank.sv ***
// Banked management registers of the integrated PHY behind an AXI4-Lite
// slave: identifier, advertisement, partner ability, cable diagnostic and
// special control/status, with a per-port alias view and an interrupt.
// Assumes all PHY-side inputs are synchronous to CLOCK_I.
// Operation
// - Identifier low word fixed, read-only.
// - Identifier high word fixed, read-only.
// - Pause advertise bit 10, writable, reset one.
// - Duplex/speed advertise bits 8..5, reset one.
// - Partner pause in bit 10, read-only.
// - Partner abilities in bits 8..5, read-only.
// - Bit 15 starts diagnostic, self-clears when done.
// - Result code in bits 14..13.
// - Bit 12 flags short under ten metres.
// - Fault distance count in bits 8..0.
// - Bit 5 shows receive polarity reversed.
// - Bit 3 forces link pass.
// - Bit 2 disables power saving, reset one.
// - Bit 1 enables remote loopback.
// - Port bank view shares the same storage.
// - Banks 46 and 48 hold only bank select and the interrupt status and mask.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "phy_mgmt_consts.svh"

module phy_mgmt_register_bank #(
   parameter logic [15:0] PHY_ID_LOW  = 16'hA5C3,   // Arbitrary value
   parameter logic [15:0] PHY_ID_HIGH = 16'h5A3C    // Arbitrary value
) (
   input  wire logic                     CLOCK_I,
   input  wire logic                     RST_I,
   input  wire logic                     CE_I,
   input  wire phy_mgmt_pkg::axil_req_t  AXI_REQ_I,
   output      phy_mgmt_pkg::axil_rsp_t  AXI_RSP_O,
   input  wire logic                     LP_VALID_I,
   input  wire phy_mgmt_pkg::ability_t   LP_ABILITY_I,
   input  wire logic                     DIAG_DONE_I,
   input  wire phy_mgmt_pkg::diag_res_t  DIAG_RESULT_I,
   input  wire logic                     POLARITY_REV_I,
   input  wire logic                     CROSSOVER_STATE_I,
   output      logic                     DIAG_START_O,
   output      phy_mgmt_pkg::ability_t   ADV_O,
   output      phy_mgmt_pkg::phy_ctl_t   PHY_CTL_O,
   output      logic                     IRQ_O
);
   import phy_mgmt_pkg::*;

   // ========================================================================
   // State
   typedef struct packed {
      axil_rsp_t   rsp;
      logic        aw_held;
      logic [5:0]  aw_idx;
      logic        w_held;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic [5:0]  rd_idx;
      logic [7:0]  rd_bank;
      logic [7:0]  bank;
      ability_t    adv;
      logic        adv_rsv9;
      ability_t    lp;
      logic        diag_en;
      diag_res_t   diag;
      logic        spc_rsv0;
      logic        pol;
      logic        xovr;
      phy_ctl_t    ctl;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_mask;
      logic        irq;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic   wr_fire;

   // Reset image of the whole state
   function automatic state_t reset_state();
      state_t r;
      r = '0;
      r.rsp.awready = 1'b1;
      r.rsp.wready = 1'b1;
      r.rsp.arready = 1'b1;
      r.bank = `PM_RST_BANK;
      r.adv = `PM_RST_ADV;
      r.ctl.pwrsave_off = `PM_RST_PWRSAVE;
      return r;
   endfunction : reset_state

   // Byte-lane merge of a 16-bit register image
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  be);
      return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   // Register image at an index in a bank: {hit, value}
   function automatic logic [16:0] image(input logic [5:0] idx,
                                         input logic [7:0] bnk,
                                         input state_t     s);
      logic [16:0] v;
      v = '0;
      if (idx == `PM_IDX_BANK_SEL) begin
         v = {1'b1, 8'h00, s.bank};
      end else if (idx == `PM_IDX_IRQ_STAT) begin
         v = {1'b1, 14'h0000, s.irq_stat};
      end else if (idx == `PM_IDX_IRQ_MASK) begin
         v = {1'b1, 14'h0000, s.irq_mask};
      end else if (bnk == `PM_BANK_PHY) begin
         unique case (idx)
            `PM_IDX_ID_LOW:  v = {1'b1, PHY_ID_LOW};
            `PM_IDX_ID_HIGH: v = {1'b1, PHY_ID_HIGH};
            `PM_IDX_ADV:     v = {1'b1, 5'h00, s.adv.pause, s.adv_rsv9,
                                  s.adv.full100, s.adv.half100, s.adv.full10,
                                  s.adv.half10, `PM_SELECTOR};
            `PM_IDX_LP:      v = {1'b1, 5'h00, s.lp.pause, 1'b0,
                                  s.lp.full100, s.lp.half100, s.lp.full10,
                                  s.lp.half10, `PM_SELECTOR};
            default:         v = '0;
         endcase
      end else if (bnk == `PM_BANK_DIAG) begin
         unique case (idx)
            `PM_IDX_DIAG:    v = {1'b1, s.diag_en, s.diag.result,
                                  s.diag.near_short_flag, 3'h0,
                                  s.diag.fault_count};
            `PM_IDX_SPECIAL: v = {1'b1, 10'h000, s.pol, s.xovr,
                                  s.ctl.force_link, s.ctl.pwrsave_off,
                                  s.ctl.remote_loopback, s.spc_rsv0};
            default:         v = '0;
         endcase
      end else if (bnk == `PM_BANK_PORT && idx == `PM_IDX_ALIAS) begin
         v = {1'b1, s.diag.near_short_flag, s.diag.result, s.diag_en,
              s.ctl.force_link, s.ctl.pwrsave_off, s.ctl.remote_loopback,
              s.diag.fault_count};
      end
      return v;
   endfunction : image

   // ========================================================================
   // Next-state logic
   always_comb begin
      logic [16:0] wimg;
      logic [15:0] m;
      logic [16:0] rimg;
      logic [1:0]  irq_set;
      logic [1:0]  irq_clr;
      logic        start;
      st_nxt = st_r;
      wimg = image(st_r.aw_idx, st_r.bank, st_r);
      m = merge(wimg[15:0], st_r.wdata, st_r.wstrb);
      rimg = image(AXI_REQ_I.araddr[7:2], st_r.bank, st_r);
      irq_set = '0;
      irq_clr = '0;
      start = 1'b0;
      wr_fire = st_r.aw_held && st_r.w_held && !st_r.rsp.bvalid;
      if (CE_I) begin
         // Live PHY status
         st_nxt.pol = POLARITY_REV_I;
         st_nxt.xovr = CROSSOVER_STATE_I;
         if (LP_VALID_I) begin
            st_nxt.lp = LP_ABILITY_I;
            irq_set[`PM_IRQ_LP] = 1'b1;
         end
         // Diagnostic completion clears the run bit and latches results
         if (st_r.diag_en && DIAG_DONE_I) begin
            st_nxt.diag_en = 1'b0;
            st_nxt.diag = DIAG_RESULT_I;
            irq_set[`PM_IRQ_DIAG] = 1'b1;
         end
         // Write address and data channels
         if (AXI_REQ_I.awvalid && st_r.rsp.awready) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_idx = AXI_REQ_I.awaddr[7:2];
            st_nxt.rsp.awready = 1'b0;
         end
         if (AXI_REQ_I.wvalid && st_r.rsp.wready) begin
            st_nxt.w_held = 1'b1;
            st_nxt.wdata = AXI_REQ_I.wdata;
            st_nxt.wstrb = AXI_REQ_I.wstrb;
            st_nxt.rsp.wready = 1'b0;
         end
         // Register write; read-only fields are never taken from m
         if (wr_fire) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.rsp.bvalid = 1'b1;
            st_nxt.rsp.bresp = wimg[16] ? `PM_RESP_OKAY : `PM_RESP_SLVERR;
            if (st_r.aw_idx == `PM_IDX_BANK_SEL) begin
               st_nxt.bank = m[7:0];
            end else if (st_r.aw_idx == `PM_IDX_IRQ_STAT) begin
               irq_clr = m[1:0] & {st_r.wstrb[0], st_r.wstrb[0]};
            end else if (st_r.aw_idx == `PM_IDX_IRQ_MASK) begin
               st_nxt.irq_mask = m[1:0];
            end else if (st_r.bank == `PM_BANK_PHY
                         && st_r.aw_idx == `PM_IDX_ADV) begin
               st_nxt.adv.pause = m[`PM_ADV_PAUSE];
               st_nxt.adv_rsv9 = m[`PM_ADV_RSV9];
               st_nxt.adv.full100 = m[`PM_ADV_F100];
               st_nxt.adv.half100 = m[`PM_ADV_H100];
               st_nxt.adv.full10 = m[`PM_ADV_F10];
               st_nxt.adv.half10 = m[`PM_ADV_H10];
            end else if (st_r.bank == `PM_BANK_DIAG
                         && st_r.aw_idx == `PM_IDX_DIAG) begin
               start = m[`PM_DIAG_EN] && st_r.wstrb[1];
            end else if (st_r.bank == `PM_BANK_DIAG
                         && st_r.aw_idx == `PM_IDX_SPECIAL) begin
               st_nxt.ctl.force_link = m[`PM_SPC_FORCE];
               st_nxt.ctl.pwrsave_off = m[`PM_SPC_PWRSAVE];
               st_nxt.ctl.remote_loopback = m[`PM_SPC_RLB];
               st_nxt.spc_rsv0 = m[`PM_SPC_RSV0];
            end else if (st_r.bank == `PM_BANK_PORT
                         && st_r.aw_idx == `PM_IDX_ALIAS) begin
               start = m[`PM_ALIAS_EN] && st_r.wstrb[1];
               st_nxt.ctl.force_link = m[`PM_ALIAS_FORCE];
               st_nxt.ctl.pwrsave_off = m[`PM_ALIAS_PWRSAVE];
               st_nxt.ctl.remote_loopback = m[`PM_ALIAS_RLB];
            end
         end
         // A start written in the finishing cycle launches a new run
         if (start) begin
            st_nxt.diag_en = 1'b1;
         end
         // Write response handshake reopens both write channels
         if (st_r.rsp.bvalid && AXI_REQ_I.bready) begin
            st_nxt.rsp.bvalid = 1'b0;
            st_nxt.rsp.awready = 1'b1;
            st_nxt.rsp.wready = 1'b1;
         end
         // Read channel: one read outstanding at a time
         if (st_r.rsp.rvalid && AXI_REQ_I.rready) begin
            st_nxt.rsp.rvalid = 1'b0;
            st_nxt.rsp.arready = 1'b1;
         end
         if (AXI_REQ_I.arvalid && st_r.rsp.arready) begin
            st_nxt.rsp.arready = 1'b0;
            st_nxt.rsp.rvalid = 1'b1;
            st_nxt.rsp.rdata = {16'h0000, rimg[15:0]};
            st_nxt.rsp.rresp = rimg[16] ? `PM_RESP_OKAY : `PM_RESP_SLVERR;
            st_nxt.rd_idx = AXI_REQ_I.araddr[7:2];
            st_nxt.rd_bank = st_r.bank;
         end
         // Sticky events: a set wins over a clear in the same cycle
         st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | irq_set;
         st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
      end
   end

   // ========================================================================
   // State register
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         st_r <= reset_state();
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from state flip-flops
   assign AXI_RSP_O = st_r.rsp;
   assign DIAG_START_O = st_r.diag_en;
   assign ADV_O = st_r.adv;
   assign PHY_CTL_O = st_r.ctl;
   assign IRQ_O = st_r.irq;

   // ========================================================================
   // Assertions
   default clocking cb @(posedge CLOCK_I iff CE_I);
   endclocking
   default disable iff (RST_I);

   property p_id_low;
      (st_r.rsp.rvalid && st_r.rd_idx == `PM_IDX_ID_LOW
       && st_r.rd_bank == `PM_BANK_PHY)
      |-> AXI_RSP_O.rdata == {16'h0000, PHY_ID_LOW};
   endproperty
   a_id_low: assert property (p_id_low)
      else $error("identifier low word wrong");

   property p_id_high;
      (st_r.rsp.rvalid && st_r.rd_idx == `PM_IDX_ID_HIGH
       && st_r.rd_bank == `PM_BANK_PHY)
      |-> AXI_RSP_O.rdata == {16'h0000, PHY_ID_HIGH};
   endproperty
   a_id_high: assert property (p_id_high)
      else $error("identifier high word wrong");

   property p_adv_pause;
      (wr_fire && st_r.aw_idx == `PM_IDX_ADV && st_r.bank == `PM_BANK_PHY
       && st_r.wstrb[1])
      |=> ADV_O.pause == $past(st_r.wdata[`PM_ADV_PAUSE]);
   endproperty
   a_adv_pause: assert property (p_adv_pause)
      else $error("pause advertisement not written");

   property p_adv_low;
      (wr_fire && st_r.aw_idx == `PM_IDX_ADV && st_r.bank == `PM_BANK_PHY
       && st_r.wstrb[0])
      |=> {ADV_O.half100, ADV_O.full10, ADV_O.half10}
          == $past(st_r.wdata[`PM_ADV_H100:`PM_ADV_H10]);
   endproperty
   a_adv_low: assert property (p_adv_low)
      else $error("ability advertisement not written");

   property p_lp_capture;
      LP_VALID_I |=> st_r.lp == $past(LP_ABILITY_I) && st_r.irq_stat[`PM_IRQ_LP];
   endproperty
   a_lp_capture: assert property (p_lp_capture)
      else $error("partner ability not captured");

   property p_diag_done;
      (DIAG_START_O && DIAG_DONE_I && !wr_fire)
      |=> !DIAG_START_O && st_r.diag == $past(DIAG_RESULT_I);
   endproperty
   a_diag_done: assert property (p_diag_done)
      else $error("diagnostic did not finish cleanly");

   property p_pol;
      1'b1 |=> st_r.pol == $past(POLARITY_REV_I);
   endproperty
   a_pol: assert property (p_pol)
      else $error("polarity status stale");

   property p_spc_write;
      (wr_fire && st_r.aw_idx == `PM_IDX_SPECIAL && st_r.bank == `PM_BANK_DIAG
       && st_r.wstrb[0])
      |=> PHY_CTL_O == $past(st_r.wdata[`PM_SPC_FORCE:`PM_SPC_RLB]);
   endproperty
   a_spc_write: assert property (p_spc_write)
      else $error("special control not written");

   property p_alias_write;
      (wr_fire && st_r.aw_idx == `PM_IDX_ALIAS && st_r.bank == `PM_BANK_PORT
       && st_r.wstrb[1])
      |=> PHY_CTL_O == $past(st_r.wdata[`PM_ALIAS_FORCE:`PM_ALIAS_RLB]);
   endproperty
   a_alias_write: assert property (p_alias_write)
      else $error("alias view does not share storage");

   property p_rsvd_bank;
      (AXI_RSP_O.rvalid && st_r.rd_idx < `PM_IDX_BANK_SEL
       && (st_r.rd_bank == `PM_BANK_RSVD_A || st_r.rd_bank == `PM_BANK_RSVD_B))
      |-> AXI_RSP_O.rresp == `PM_RESP_SLVERR && AXI_RSP_O.rdata == 32'h00000000;
   endproperty
   a_rsvd_bank: assert property (p_rsvd_bank)
      else $error("reserved bank answered a register");

   property p_adv_ro;
      (AXI_RSP_O.rvalid && st_r.rd_idx == `PM_IDX_ADV
       && st_r.rd_bank == `PM_BANK_PHY)
      |-> AXI_RSP_O.rdata[15:11] == 5'h00 && AXI_RSP_O.rdata[4:0] == `PM_SELECTOR;
   endproperty
   a_adv_ro: assert property (p_adv_ro)
      else $error("read-only advertisement bits changed");

   // A start bit written to the diagnostic register launches a run
   property p_diag_start;
      (wr_fire && st_r.aw_idx == `PM_IDX_DIAG && st_r.bank == `PM_BANK_DIAG
       && st_r.wstrb[1] && st_r.wdata[`PM_DIAG_EN])
      |=> DIAG_START_O;
   endproperty
   a_diag_start: assert property (p_diag_start)
      else $error("diagnostic start not taken");

   // Partner abilities only change on a partner update, never by a write
   property p_lp_ro;
      (wr_fire && st_r.aw_idx == `PM_IDX_LP && st_r.bank == `PM_BANK_PHY
       && !LP_VALID_I)
      |=> $stable(st_r.lp);
   endproperty
   a_lp_ro: assert property (p_lp_ro)
      else $error("partner ability changed by a write");

   c_diag_run: cover property (DIAG_START_O ##[1:20] !DIAG_START_O);
   c_lp_update: cover property (LP_VALID_I ##1 IRQ_O);
   c_rsvd_read: cover property (AXI_RSP_O.rvalid
                                && AXI_RSP_O.rresp == `PM_RESP_SLVERR);
   c_alias: cover property (wr_fire && st_r.bank == `PM_BANK_PORT);
   c_ro_write: cover property (wr_fire && st_r.aw_idx == `PM_IDX_LP);

endmodule : phy_mgmt_register_bank

// *** dv/test_phy_mgmt_register_bank.sv ***
// Self-checking testbench of the PHY management register bank.
// Assumes the package, the constants header and the design compile first.
`timescale 1ns/1ps
`include "phy_mgmt_consts.svh"

module test_phy_mgmt_register_bank;
   import phy_mgmt_pkg::*;

   // ======================================================================
   // Signals
   localparam logic [15:0] ID_LOW  = 16'h3C5A;   // Arbitrary value
   localparam logic [15:0] ID_HIGH = 16'hC3A5;   // Arbitrary value

   logic      clk, rst, ce, lp_valid, diag_done, pol_rev, xover, diag_start, irq;
   axil_req_t req;
   axil_rsp_t rsp;
   ability_t  lp_ab, adv;
   diag_res_t dres;
   phy_ctl_t  ctl;
   int        bad_count, cmp_count;

   // ======================================================================
   // Design under test
   phy_mgmt_register_bank #(.PHY_ID_LOW(ID_LOW), .PHY_ID_HIGH(ID_HIGH)) dut (
      .CLOCK_I(clk), .RST_I(rst), .CE_I(ce), .AXI_REQ_I(req), .AXI_RSP_O(rsp),
      .LP_VALID_I(lp_valid), .LP_ABILITY_I(lp_ab), .DIAG_DONE_I(diag_done),
      .DIAG_RESULT_I(dres), .POLARITY_REV_I(pol_rev), .CROSSOVER_STATE_I(xover),
      .DIAG_START_O(diag_start), .ADV_O(adv), .PHY_CTL_O(ctl), .IRQ_O(irq));

   // ======================================================================
   // Clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ======================================================================
   // Helpers
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // Write one word; address and data held until each is taken
   task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] eresp);
      int   n;
      logic done;
      n = 0;
      done = 1'b0;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr  <= {idx, 2'h0};
      req.wvalid  <= 1'b1;
      req.wdata   <= {16'h0, d};
      req.wstrb   <= 4'hF;
      req.bready  <= 1'b1;
      while (!done && n < 100) begin
         @(posedge clk);
         n++;
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) begin
            done = 1'b1;
            req.bready <= 1'b0;
            chk("bresp", 32'(rsp.bresp), 32'(eresp));
         end
      end
      if (!done) chk("write hang", 32'h0, 32'h1);
   endtask : wr

   // Read one word and compare data and response
   task automatic rd(input logic [5:0] idx, input logic [15:0] exp, input logic [1:0] eresp);
      int   n;
      logic done;
      n = 0;
      done = 1'b0;
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr  <= {idx, 2'h0};
      req.rready  <= 1'b1;
      while (!done && n < 100) begin
         @(posedge clk);
         n++;
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) begin
            done = 1'b1;
            req.rready <= 1'b0;
            chk($sformatf("rdata idx %h", idx), rsp.rdata, {16'h0, exp});
            chk("rresp", 32'(rsp.rresp), 32'(eresp));
         end
      end
      if (!done) chk("read hang", 32'h0, 32'h1);
   endtask : rd

   task automatic sel(input logic [7:0] bank);
      wr(`PM_IDX_BANK_SEL, {8'h0, bank}, `PM_RESP_OKAY);
   endtask : sel

   // Run one diagnostic to completion with the given outcome
   task automatic run_diag(input logic [5:0] idx, input logic [15:0] d, input diag_res_t r);
      wr(idx, d, `PM_RESP_OKAY);
      tick(1);
      chk("diag running", 32'(diag_start), 32'h1);
      diag_done <= 1'b1;
      dres      <= r;
      tick(1);
      diag_done <= 1'b0;
      tick(2);
      chk("diag cleared", 32'(diag_start), 32'h0);
   endtask : run_diag

   // ======================================================================
   // Scenarios
   task automatic t_reset;
      rd(`PM_IDX_BANK_SEL, 16'h0000, `PM_RESP_OKAY);
      chk("adv reset", 32'(adv), 32'h1F);
      chk("ctl reset", 32'(ctl), 32'h2);
      chk("irq reset", 32'(irq), 32'h0);
      sel(`PM_BANK_PHY);
      rd(`PM_IDX_ID_LOW, ID_LOW, `PM_RESP_OKAY);
      rd(`PM_IDX_ID_HIGH, ID_HIGH, `PM_RESP_OKAY);
      rd(`PM_IDX_ADV, 16'h05E1, `PM_RESP_OKAY);
      rd(`PM_IDX_LP, 16'h0001, `PM_RESP_OKAY);
   endtask : t_reset

   task automatic t_advert;
      logic [15:0] d;
      wr(`PM_IDX_ID_LOW, 16'hFFFF, `PM_RESP_OKAY);
      rd(`PM_IDX_ID_LOW, ID_LOW, `PM_RESP_OKAY);
      for (int i = 5; i < 11; i++) begin
         d = 16'h0001 << i;
         wr(`PM_IDX_ADV, d, `PM_RESP_OKAY);
         tick(1);
         chk("adv out", 32'(adv), 32'({d[10], d[8:5]}));
         rd(`PM_IDX_ADV, d | 16'h0001, `PM_RESP_OKAY);
      end
      wr(`PM_IDX_ADV, 16'hFFFF, `PM_RESP_OKAY);
      rd(`PM_IDX_ADV, 16'h07E1, `PM_RESP_OKAY);
   endtask : t_advert

   task automatic t_partner;
      lp_valid <= 1'b1;
      lp_ab    <= 5'h15;
      tick(1);
      lp_valid <= 1'b0;
      tick(1);
      rd(`PM_IDX_LP, 16'h04A1, `PM_RESP_OKAY);
      wr(`PM_IDX_LP, 16'hFFFF, `PM_RESP_OKAY);
      rd(`PM_IDX_LP, 16'h04A1, `PM_RESP_OKAY);
      rd(`PM_IDX_IRQ_STAT, 16'h0002, `PM_RESP_OKAY);
      chk("irq masked", 32'(irq), 32'h0);
      wr(`PM_IDX_IRQ_MASK, 16'h0002, `PM_RESP_OKAY);
      tick(1);
      chk("irq raised", 32'(irq), 32'h1);
      wr(`PM_IDX_IRQ_STAT, 16'h0002, `PM_RESP_OKAY);
      tick(1);
      chk("irq cleared", 32'(irq), 32'h0);
      rd(`PM_IDX_IRQ_STAT, 16'h0000, `PM_RESP_OKAY);
   endtask : t_partner

   // Clock enable low: a partner update in that cycle is not taken
   task automatic t_freeze;
      ce       <= 1'b0;
      lp_valid <= 1'b1;
      lp_ab    <= 5'h0A;
      tick(1);
      lp_valid <= 1'b0;
      ce       <= 1'b1;
      tick(1);
      rd(`PM_IDX_LP, 16'h04A1, `PM_RESP_OKAY);
      rd(`PM_IDX_IRQ_STAT, 16'h0000, `PM_RESP_OKAY);
      chk("adv frozen", 32'(adv), 32'h1F);
   endtask : t_freeze

   task automatic t_diag;
      diag_res_t r;
      sel(`PM_BANK_DIAG);
      wr(`PM_IDX_IRQ_MASK, 16'h0001, `PM_RESP_OKAY);
      for (int c = 0; c < 4; c++) begin
         r = {c == 2, diag_code_t'(c), 2'(c), 7'h55};
         run_diag(`PM_IDX_DIAG, 16'h8000, r);
         chk("diag irq", 32'(irq), 32'h1);
         rd(`PM_IDX_DIAG, {1'b0, r[10:9], r[11], 3'h0, r[8:0]}, `PM_RESP_OKAY);
         wr(`PM_IDX_IRQ_STAT, 16'h0001, `PM_RESP_OKAY);
      end
      sel(`PM_BANK_PORT);
      rd(`PM_IDX_ALIAS, {r[11], r[10:9], 4'h2, r[8:0]}, `PM_RESP_OKAY);
      r = {1'b1, DIAG_SHORT, 9'h1FF};
      run_diag(`PM_IDX_ALIAS, 16'h1400, r);
      sel(`PM_BANK_DIAG);
      rd(`PM_IDX_DIAG, 16'h51FF, `PM_RESP_OKAY);
   endtask : t_diag

   task automatic t_special;
      pol_rev <= 1'b1;
      xover   <= 1'b1;
      wr(`PM_IDX_SPECIAL, 16'hFFFF, `PM_RESP_OKAY);
      tick(1);
      chk("ctl set", 32'(ctl), 32'h7);
      rd(`PM_IDX_SPECIAL, 16'h003F, `PM_RESP_OKAY);
      wr(`PM_IDX_SPECIAL, 16'h0000, `PM_RESP_OKAY);
      tick(1);
      chk("ctl clear", 32'(ctl), 32'h0);
      pol_rev <= 1'b0;
      rd(`PM_IDX_SPECIAL, 16'h0010, `PM_RESP_OKAY);
      sel(`PM_BANK_PORT);
      wr(`PM_IDX_ALIAS, 16'h0E00, `PM_RESP_OKAY);
      sel(`PM_BANK_DIAG);
      rd(`PM_IDX_SPECIAL, 16'h001E, `PM_RESP_OKAY);
   endtask : t_special

   task automatic t_banks;
      logic [7:0] b;
      for (int i = 0; i < 2; i++) begin
         b = i ? `PM_BANK_RSVD_B : `PM_BANK_RSVD_A;
         sel(b);
         rd(`PM_IDX_ID_LOW, 16'h0000, `PM_RESP_SLVERR);
         rd(`PM_IDX_DIAG, 16'h0000, `PM_RESP_SLVERR);
         wr(`PM_IDX_SPECIAL, 16'h0000, `PM_RESP_SLVERR);
         rd(`PM_IDX_BANK_SEL, {8'h0, b}, `PM_RESP_OKAY);
      end
      rd(6'h3F, 16'h0000, `PM_RESP_SLVERR);
      chk("ctl kept", 32'(ctl), 32'h7);
   endtask : t_banks

   // ======================================================================
   // Verdict and end of run
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done

   // Main sequence
   initial begin
      req = '0;
      rst = 1'b1;
      ce = 1'b1;
      lp_valid = 1'b0;
      lp_ab = '0;
      diag_done = 1'b0;
      dres = '0;
      pol_rev = 1'b0;
      xover = 1'b0;
      bad_count = 0;
      cmp_count = 0;
      tick(10);
      rst <= 1'b0;
      t_reset();
      t_advert();
      t_partner();
      t_freeze();
      t_diag();
      t_special();
      t_banks();
      test_done();
   end

   // Watchdog against a hung handshake
   initial begin
      tick(20000);
      bad_count++;
      test_done();
   end

endmodule : test_phy_mgmt_register_bank
